// *** hdl/mdc_pkg.sv ***
// Constants and carrier types for the metering datapath configuration block
package mdc_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam int          ADDR_W                       = 12;
    localparam int          DATA_W                       = 32;
    localparam logic [11:0] DATAPATH_CONFIGURATION_ADDR  = 12'h060;
    localparam logic [11:0] PHC_CURRENT_RMS_TENCYCLE_MIRROR_ADDR      = 12'h6b7;
    localparam logic [11:0] PHC_VOLTAGE_RMS_TENCYCLE_MIRROR_ADDR      = 12'h6b8;
    localparam logic [11:0] NEUTRAL_CURRENT_WAVEFORM_MIRROR_ADDR      = 12'h6b9;
    localparam logic [11:0] NEUTRAL_CURRENT_RMS_MIRROR_ADDR           = 12'h6ba;
    localparam logic [11:0] NEUTRAL_CURRENT_HALFCYCLE_RMS_MIRROR_ADDR = 12'h6bb;
    localparam logic [11:0] NEUTRAL_CURRENT_TENCYCLE_RMS_MIRROR_ADDR  = 12'h6bc;
    localparam int          MIRROR_COUNT                 = 6;

    // ------------------------------------------------------------
    // Configuration field positions and reset values
    // ------------------------------------------------------------
    localparam int          REACTIVE_LPF_BYPASS_BIT      = 13;
    localparam int          ACTIVE_LPF_BYPASS_BIT        = 12;
    localparam int          NEUTRAL_INTEGRATOR_EN_BIT    = 11;
    localparam int          PHC_NOMINAL_VOLTAGE_BIT      = 10;
    localparam int          PHB_NOMINAL_VOLTAGE_BIT      = 9;
    localparam int          PHA_NOMINAL_VOLTAGE_BIT      = 8;
    localparam int          RMS_SAMPLE_SOURCE_BIT        = 7;
    localparam int          ZERO_CROSS_SOURCE_BIT        = 6;
    localparam int          PHASE_INTEGRATOR_EN_BIT      = 5;
    localparam int          MULTIPOINT_COMP_EN_BIT       = 4;
    localparam int          HIGHPASS_DISABLE_ALL_BIT     = 3;
    localparam int          CURRENT_SUM_SELECT_LSB       = 0;
    localparam logic [31:0] CONFIG_WRITABLE_MASK         = 32'h0000_3ffb;
    localparam logic [31:0] CONFIG_RESET                 = 32'h0000_0000;
    localparam logic [31:0] MIRROR_RESET                 = 32'h0000_0000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  SUM_PHASES                   = 2'h0;
    localparam logic [1:0]  SUM_PLUS_NEUTRAL             = 2'h1;
    localparam logic [1:0]  SUM_MINUS_NEUTRAL            = 2'h2;
    localparam logic [1:0]  SUM_PHASES_ALT               = 2'h3;
    localparam logic [3:0]  REGION_DISABLED              = 4'hf;
    localparam int          PHASE_COUNT                  = 3;
    localparam int          SUM_W                        = DATA_W + 2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       reactive_lpf_bypass;
        logic       active_lpf_bypass;
        logic       neutral_integrator_enable;
        logic       phc_nominal_voltage_use;
        logic       phb_nominal_voltage_use;
        logic       pha_nominal_voltage_use;
        logic       rms_sample_source;
        logic       zero_cross_source;
        logic       phase_integrator_enable;
        logic       multipoint_comp_enable;
        logic       highpass_disable_all;
        logic [1:0] current_sum_select;
    } mdc_ctrl_type;

    typedef struct packed {
        logic signed [DATA_W-1:0] pha;
        logic signed [DATA_W-1:0] phb;
        logic signed [DATA_W-1:0] phc;
        logic signed [DATA_W-1:0] neutral;
    } mdc_wave_type;

    // Index 0 is the mirror at the lowest address
    typedef logic [MIRROR_COUNT-1:0][DATA_W-1:0] mdc_mirror_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr_en;
        logic [DATA_W-1:0] wr_data;
        logic              rd_en;
    } mdc_req_type;

endpackage

// *** hdl/mdc_config.sv ***
// Datapath configuration register, mirror registers and multipoint region select
// Function
// - Bit 13 bypasses reactive power low-pass filter
// - Bit 12 bypasses active power low-pass filter
// - Bit 11 enables neutral channel integrator
// - Bits 10..8 use nominal voltage per phase
// - Bit 7 picks rms source; 0 filtered
// - Bit 6 picks zero-crossing detector source
// - Bit 5 enables phase current integrators only
// - Bit 4 enables six-step multipoint gain
// - Gain step from rms versus thresholds
// - Bit 3 disables every high-pass filter
// - Two-bit field selects current sum form
// - Phase C and neutral mirrors are readable
module mdc_config
    import mdc_pkg::*;
#(
    parameter int MT_LEVELS = 6                                   // Gain steps per channel
) (
    input  wire logic                                      mclk,                // 100 MHz clock
    input  wire logic                                      reset,               // Sync reset
    input  wire mdc_pkg::mdc_req_type                      reg_req,             // Register request
    output logic [mdc_pkg::DATA_W-1:0]                     reg_rd_data,         // Read data
    output logic                                           reg_rd_valid,        // Read data strobe
    input  wire logic                                      results_load,        // Mirror update
    input  wire mdc_pkg::mdc_mirror_type                   results,             // New mirror values
    input  wire mdc_pkg::mdc_wave_type                     current_waves,       // Current samples
    input  wire logic [2:0][mdc_pkg::DATA_W-1:0]           channel_current_rms, // Per phase rms
    input  wire logic [MT_LEVELS-2:0][mdc_pkg::DATA_W-1:0] multipoint_low_threshold,  // Step down
    input  wire logic [MT_LEVELS-2:0][mdc_pkg::DATA_W-1:0] multipoint_high_threshold, // Step up
    output mdc_pkg::mdc_ctrl_type                          ctrl,                // Datapath steering
    output logic signed [mdc_pkg::SUM_W-1:0]               current_sum_result,  // Current sum
    output logic [2:0][3:0]                                multipoint_gain_factor // Step in use
);
    import mdc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0]        cfg;
        mdc_mirror_type           mirror;
        logic [DATA_W-1:0]        rd_data;
        logic                     rd_valid;
        logic signed [SUM_W-1:0]  current_sum;
        logic [2:0][3:0]          region;
    } mdc_state_type;

    localparam logic [3:0] TOP_REGION = 4'(MT_LEVELS - 1);

    mdc_state_type state_q;
    mdc_state_type state_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [ADDR_W-1:0]       mirror_off;
        logic signed [SUM_W-1:0] phase_sum;
        logic signed [SUM_W-1:0] neutral_ext;
        logic [3:0]              cur;
        state_d     = state_q;
        mirror_off  = reg_req.addr - PHC_CURRENT_RMS_TENCYCLE_MIRROR_ADDR;
        phase_sum   = SUM_W'(current_waves.pha) + SUM_W'(current_waves.phb)
                    + SUM_W'(current_waves.phc);
        neutral_ext = SUM_W'(current_waves.neutral);
        cur         = 4'h0;

        // Register writes
        if (reg_req.wr_en) begin
            if (reg_req.addr == DATAPATH_CONFIGURATION_ADDR) begin
                state_d.cfg = reg_req.wr_data & CONFIG_WRITABLE_MASK;
            end else if (reg_req.addr >= PHC_CURRENT_RMS_TENCYCLE_MIRROR_ADDR &&
                         reg_req.addr <= NEUTRAL_CURRENT_TENCYCLE_RMS_MIRROR_ADDR) begin
                state_d.mirror[mirror_off[2:0]] = reg_req.wr_data;
            end
        end

        // Datapath refresh of the mirrors takes priority over a host write
        if (results_load) begin
            state_d.mirror = results;
        end

        // Register reads, one cycle latency; unmapped reads return zero
        state_d.rd_valid = reg_req.rd_en;
        state_d.rd_data  = '0;
        if (reg_req.rd_en) begin
            if (reg_req.addr == DATAPATH_CONFIGURATION_ADDR) begin
                state_d.rd_data = state_q.cfg & CONFIG_WRITABLE_MASK;
            end else if (reg_req.addr >= PHC_CURRENT_RMS_TENCYCLE_MIRROR_ADDR &&
                         reg_req.addr <= NEUTRAL_CURRENT_TENCYCLE_RMS_MIRROR_ADDR) begin
                state_d.rd_data = state_q.mirror[mirror_off[2:0]];
            end
        end

        // Current sum form
        case (state_q.cfg[CURRENT_SUM_SELECT_LSB +: 2])
            SUM_PHASES:        state_d.current_sum = phase_sum;
            SUM_PLUS_NEUTRAL:  state_d.current_sum = phase_sum + neutral_ext;
            SUM_MINUS_NEUTRAL: state_d.current_sum = phase_sum - neutral_ext;
            SUM_PHASES_ALT:    state_d.current_sum = phase_sum;
            default:           state_d.current_sum = phase_sum;
        endcase

        // Multipoint step per phase, with hysteresis between thresholds
        for (int p = 0; p < PHASE_COUNT; p++) begin
            cur = state_q.region[p];
            if (!state_q.cfg[MULTIPOINT_COMP_EN_BIT]) begin
                state_d.region[p] = REGION_DISABLED;
            end else if (cur > TOP_REGION) begin
                state_d.region[p] = 4'h0;
            end else if (cur < TOP_REGION &&
                         channel_current_rms[p] >= multipoint_high_threshold[cur]) begin
                state_d.region[p] = cur + 4'h1;
            end else if (cur != 4'h0 &&
                         channel_current_rms[p] < multipoint_low_threshold[cur - 4'h1]) begin
                state_d.region[p] = cur - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q.cfg         <= CONFIG_RESET;
            state_q.mirror      <= {MIRROR_COUNT{MIRROR_RESET}};
            state_q.rd_data     <= '0;
            state_q.rd_valid    <= 1'b0;
            state_q.current_sum <= '0;
            state_q.region      <= {PHASE_COUNT{REGION_DISABLED}};
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all taken from registered state
    // ------------------------------------------------------------
    assign ctrl.reactive_lpf_bypass       = state_q.cfg[REACTIVE_LPF_BYPASS_BIT];
    assign ctrl.active_lpf_bypass         = state_q.cfg[ACTIVE_LPF_BYPASS_BIT];
    assign ctrl.neutral_integrator_enable = state_q.cfg[NEUTRAL_INTEGRATOR_EN_BIT];
    assign ctrl.phc_nominal_voltage_use   = state_q.cfg[PHC_NOMINAL_VOLTAGE_BIT];
    assign ctrl.phb_nominal_voltage_use   = state_q.cfg[PHB_NOMINAL_VOLTAGE_BIT];
    assign ctrl.pha_nominal_voltage_use   = state_q.cfg[PHA_NOMINAL_VOLTAGE_BIT];
    assign ctrl.rms_sample_source         = state_q.cfg[RMS_SAMPLE_SOURCE_BIT];
    assign ctrl.zero_cross_source         = state_q.cfg[ZERO_CROSS_SOURCE_BIT];
    assign ctrl.phase_integrator_enable   = state_q.cfg[PHASE_INTEGRATOR_EN_BIT];
    assign ctrl.multipoint_comp_enable    = state_q.cfg[MULTIPOINT_COMP_EN_BIT];
    assign ctrl.highpass_disable_all      = state_q.cfg[HIGHPASS_DISABLE_ALL_BIT];
    assign ctrl.current_sum_select        = state_q.cfg[CURRENT_SUM_SELECT_LSB +: 2];

    assign reg_rd_data            = state_q.rd_data;
    assign reg_rd_valid           = state_q.rd_valid;
    assign current_sum_result     = state_q.current_sum;
    assign multipoint_gain_factor = state_q.region;

endmodule

// *** test/mdc_config_assertions.sv ***
// Concurrent checks on the configuration block ports
module mdc_config_checker
    import mdc_pkg::*;
(
    input logic                  mclk,                  // Clock
    input logic                  reset,                 // Sync reset
    input mdc_pkg::mdc_req_type  reg_req,               // Register request
    input logic [31:0]           reg_rd_data,           // Read data
    input logic                  reg_rd_valid,          // Read strobe
    input mdc_pkg::mdc_wave_type current_waves,         // Current samples
    input mdc_pkg::mdc_ctrl_type ctrl,                  // Steering
    input logic signed [33:0]    current_sum_result,    // Sum
    input logic [2:0][3:0]       multipoint_gain_factor // Steps
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire cfg_wr = reg_req.wr_en && reg_req.addr == DATAPATH_CONFIGURATION_ADDR;
    wire cfg_rd = reg_req.rd_en && reg_req.addr == DATAPATH_CONFIGURATION_ADDR;
    function automatic logic signed [33:0] sum_f(mdc_wave_type w, logic [1:0] s);
        logic signed [33:0] t;
        t = w.pha + w.phb + w.phc;
        if (s == SUM_PLUS_NEUTRAL) return t + w.neutral;
        if (s == SUM_MINUS_NEUTRAL) return t - w.neutral;
        return t;
    endfunction
    wire signed [33:0] sum_exp    = sum_f(current_waves, ctrl.current_sum_select);
    wire [12:0]        cfg_fields = {reg_req.wr_data[13:3], reg_req.wr_data[1:0]};
    sequence mt_on_s;
        $rose(ctrl.multipoint_comp_enable);
    endsequence
    sequence mt_held_s;
        ctrl.multipoint_comp_enable [*2];
    endsequence
    rd_answer_a: assert property (reg_req.rd_en |=> reg_rd_valid)
        else $error("read not answered");
    rd_cause_a: assert property (reg_rd_valid |-> $past(reg_req.rd_en))
        else $error("stray read strobe");
    cfg_load_a: assert property (cfg_wr |=> ctrl == $past(cfg_fields))
        else $error("config fields not loaded");
    ctrl_hold_a: assert property (!cfg_wr |=> $stable(ctrl))
        else $error("config changed without write");
    cfg_rsvd_a: assert property (cfg_rd |=> reg_rd_data[31:14] == 0 && !reg_rd_data[2])
        else $error("reserved bits not zero");
    mt_off_a: assert property (!ctrl.multipoint_comp_enable |=> multipoint_gain_factor == 12'hfff)
        else $error("step shown while disabled");
    mt_start_a: assert property (mt_on_s |=> multipoint_gain_factor == 12'h000)
        else $error("steps not started at zero");
    mt_range_a: assert property (mt_held_s |-> multipoint_gain_factor[0] <= 4'h5 &&
        multipoint_gain_factor[1] <= 4'h5 && multipoint_gain_factor[2] <= 4'h5)
        else $error("step out of range");
    sum_form_a: assert property (1'b1 |=> current_sum_result == $past(sum_exp))
        else $error("current sum wrong");
endmodule
bind mdc_config mdc_config_checker i_mdc_config_checker (.mclk(mclk), .reset(reset),
    .reg_req(reg_req), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .current_waves(current_waves), .ctrl(ctrl), .current_sum_result(current_sum_result),
    .multipoint_gain_factor(multipoint_gain_factor));

// *** test/mdc_host_model.sv ***
// Host model that issues single register writes and reads
module mdc_host_model (
    input  logic                 mclk,         // Clock
    output mdc_pkg::mdc_req_type reg_req,      // Request to device
    input  logic [31:0]          reg_rd_data,  // Read data
    input  logic                 reg_rd_valid  // Read strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // Request taken at one rising edge, then address and data scrambled
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_req = '{addr: a, wr_en: w, wr_data: d, rd_en: !w};
        @(negedge mclk);
        reg_req = '{addr: ~a, wr_en: 1'b0, wr_data: ~d, rd_en: 1'b0};
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
        access(1'b0, a, 32'h0);
        d = reg_rd_data;
        ok = reg_rd_valid;
    endtask
endmodule

// *** test/metering_datapath_config_test.sv ***
// Self-checking bench for the datapath configuration block
module metering_datapath_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mdc_pkg::*;
    logic mclk = 0, reset = 1, results_load = 0, reg_rd_valid, ok;
    mdc_req_type reg_req;
    logic [31:0] reg_rd_data, rdv;
    mdc_mirror_type results = '0;
    mdc_wave_type current_waves = '0;
    logic [2:0][31:0] rms_in = '0;
    logic [4:0][31:0] lo_thr = '0, hi_thr = '0;
    mdc_ctrl_type ctrl;
    logic signed [33:0] current_sum_result;
    logic [2:0][3:0] multipoint_gain_factor;
    int n_mismatch = 0, checks_done = 0;
    always #5 mclk = ~mclk;
    mdc_config #(.MT_LEVELS(6)) i_mdc_config (.mclk(mclk), .reset(reset), .reg_req(reg_req),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .results_load(results_load),
        .results(results), .current_waves(current_waves), .channel_current_rms(rms_in),
        .multipoint_low_threshold(lo_thr), .multipoint_high_threshold(hi_thr), .ctrl(ctrl),
        .current_sum_result(current_sum_result), .multipoint_gain_factor(multipoint_gain_factor));
    mdc_host_model i_mdc_host_model (.mclk(mclk), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_fields();
        logic [31:0] v;
        i_mdc_host_model.rd(DATAPATH_CONFIGURATION_ADDR, rdv, ok);
        chk({ok, rdv, multipoint_gain_factor}, {1'b1, 32'h0, 12'hfff});
        for (int i = 0; i < 15; i++) begin
            v = (i == 14) ? 32'hffff_ffff : 32'h1 << i;
            i_mdc_host_model.access(1'b1, DATAPATH_CONFIGURATION_ADDR, v);
            chk(ctrl, {v[13:3], v[1:0]});
            i_mdc_host_model.rd(DATAPATH_CONFIGURATION_ADDR, rdv, ok);
            chk({ok, rdv}, {1'b1, v & 32'h0000_3ffb});
        end
        $display("field test done");
    endtask
    task automatic t_sum();
        logic [33:0] e[4] = '{60, 67, 53, 60};
        current_waves = '{pha: 10, phb: 20, phc: 30, neutral: 7};
        for (int s = 0; s < 4; s++) begin
            i_mdc_host_model.access(1'b1, DATAPATH_CONFIGURATION_ADDR, 32'(s));
            @(negedge mclk);
            chk(current_sum_result, e[s]);
        end
        $display("sum test done");
    endtask
    task automatic t_mirror();
        for (int k = 0; k < 6; k++) results[k] = 32'h5a00_0000 + k;
        results_load = 1;
        @(negedge mclk);
        results_load = 0;
        for (int k = 0; k < 6; k++) begin
            i_mdc_host_model.rd(PHC_CURRENT_RMS_TENCYCLE_MIRROR_ADDR + 12'(k), rdv, ok);
            chk({ok, rdv}, {1'b1, 32'h5a00_0000 + k});
        end
        i_mdc_host_model.access(1'b1, NEUTRAL_CURRENT_RMS_MIRROR_ADDR, 32'hc0de_0001);
        i_mdc_host_model.rd(NEUTRAL_CURRENT_RMS_MIRROR_ADDR, rdv, ok);
        chk(rdv, 32'hc0de_0001);
        results_load = 1;
        i_mdc_host_model.access(1'b1, NEUTRAL_CURRENT_RMS_MIRROR_ADDR, 32'hc0de_0002);
        results_load = 0;
        i_mdc_host_model.rd(NEUTRAL_CURRENT_RMS_MIRROR_ADDR, rdv, ok);
        chk(rdv, 32'h5a00_0003);
        i_mdc_host_model.rd(12'h6bd, rdv, ok);
        chk({ok, rdv}, 33'h1_0000_0000);
        $display("mirror test done");
    endtask
    task automatic t_mt();
        for (int k = 0; k < 5; k++) begin
            hi_thr[k] = 100 * (k + 1);
            lo_thr[k] = 50 * (k + 1);
        end
        rms_in = '{1000, 0, 250};
        i_mdc_host_model.access(1'b1, DATAPATH_CONFIGURATION_ADDR, 32'h10);
        repeat (10) @(negedge mclk);
        chk(multipoint_gain_factor, 12'h502);
        rms_in[0] = 60;
        repeat (5) @(negedge mclk);
        chk(multipoint_gain_factor, 12'h501);
        i_mdc_host_model.access(1'b1, DATAPATH_CONFIGURATION_ADDR, 32'h0);
        @(negedge mclk);
        chk(multipoint_gain_factor, 12'hfff);
        $display("multipoint test done");
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        reset = 0;
        t_fields();
        t_sum();
        t_mirror();
        t_mt();
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        n_mismatch++;
        give_verdict();
    end
endmodule
